// [design/sram_host_ctrl.sv]
// Host-side controller driving an asynchronous 16-bit SRAM with byte lanes
//
// Summary of operation
// - Array write happens only while select, a lane strobe and write strobe overlap.
// - All write strobes valid to start; any one going inactive ends the write.
// - Write data stable 9 ns before the ending edge; may change right after.
// - Write strobe low at least 12 ns, 17 ns if output enable stays low.
// - With outputs enabled, write cycle covers turn-off delay plus data setup.
// - Address valid 12 ns before write end; zero setup and hold around strobe.
// - Select and lane low 12 ns before write end; writes spaced 20 ns apart.
// - For enable-governed reads, address valid before or with select falling.
`timescale 1ns/10ps
`default_nettype none

module sram_host_ctrl
  import sram_host_pkg::*;
#(
  parameter int ADDR_W = ADDR_WIDTH,
  parameter int DATA_W = DATA_WIDTH
) (
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              reset_n_i,
  // User request side
  input  wire logic              req_i,
  input  wire logic              req_write_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [DATA_W-1:0] req_wdata_i,
  input  wire logic [1:0]        req_lane_en_i,
  output logic                   ready_o,
  output logic                   done_o,
  output logic [DATA_W-1:0]      rdata_o,
  // SRAM pins
  output logic [ADDR_W-1:0]      sram_addr_o,
  output logic                   device_select_n_o,
  output logic                   output_drive_enable_n_o,
  output logic                   write_strobe_n_o,
  output logic                   upper_lane_strobe_n_o,
  output logic                   lower_lane_strobe_n_o,
  output logic [DATA_W-1:0]      sram_data_o,
  output logic                   sram_data_oe_o,
  input  wire logic [DATA_W-1:0] sram_data_i
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_RD, ST_WR_SETUP, ST_WR_TURNOFF, ST_WR_DATA, ST_WR_END, ST_RECOVER
  } state_e;

  state_e                state_r,   state_nxt;
  logic [ADDR_W-1:0]     addr_r,    addr_nxt;
  logic                  cs_n_r,    cs_n_nxt;
  logic                  oe_n_r,    oe_n_nxt;
  logic                  we_n_r,    we_n_nxt;
  logic [1:0]            lanes_n_r, lanes_n_nxt;
  logic [DATA_W-1:0]     wdata_r,   wdata_nxt;
  logic                  doe_r,     doe_nxt;
  logic [DATA_W-1:0]     rdata_r,   rdata_nxt;
  logic                  ready_r,   ready_nxt;
  logic                  done_r,    done_nxt;
  logic [DATA_W-1:0]     data_meta_r;
  logic [DATA_W-1:0]     data_sync_r;
  logic                  timer_load;
  logic [TIMER_WIDTH-1:0] timer_value;
  logic                  timer_last;

  // Span timer shared by the read, turn-off, write data and recovery waits
  sram_wait_timer #(
    .WIDTH        (TIMER_WIDTH)
  ) u_timer (
    .ref_clk_i    (ref_clk_i),
    .reset_n_i    (reset_n_i),
    .load_i       (timer_load),
    .load_value_i (timer_value),
    .last_o       (timer_last)
  );

  // Two-stage synchroniser on the data pins
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_meta_r <= '0;
      data_sync_r <= '0;
    end else begin
      data_meta_r <= sram_data_i;
      data_sync_r <= data_meta_r;
    end
  end

  // Sequencer next-state and pin next values
  always_comb begin
    state_nxt   = state_r;
    addr_nxt    = addr_r;
    cs_n_nxt    = cs_n_r;
    oe_n_nxt    = oe_n_r;
    we_n_nxt    = we_n_r;
    lanes_n_nxt = lanes_n_r;
    wdata_nxt   = wdata_r;
    doe_nxt     = doe_r;
    rdata_nxt   = rdata_r;
    done_nxt    = 1'b0;
    timer_load  = 1'b0;
    timer_value = '0;
    case (state_r)
      ST_IDLE: begin
        if (req_i && ready_r) begin
          // Address, select and lanes change on the same edge
          addr_nxt    = req_addr_i;
          cs_n_nxt    = 1'b0;
          lanes_n_nxt = (req_lane_en_i == 2'h0) ? ~LANES_ALL : ~req_lane_en_i;
          wdata_nxt   = req_wdata_i;
          if (req_write_i) begin
            state_nxt = ST_WR_SETUP; // output enable stays high for writes
          end else begin
            oe_n_nxt    = 1'b0;
            timer_load  = 1'b1;
            timer_value = TIMER_WIDTH'(READ_WAIT_CYC); // access plus sync
            state_nxt   = ST_RD;
          end
        end
      end
      ST_RD: begin
        if (timer_last) begin
          rdata_nxt   = data_sync_r; // held address gives settled data
          done_nxt    = 1'b1;
          cs_n_nxt    = 1'b1;
          oe_n_nxt    = 1'b1;
          lanes_n_nxt = LANES_OFF;
          timer_load  = 1'b1;
          timer_value = TIMER_WIDTH'(RELEASE_CYC); // float time before next access
          state_nxt   = ST_RECOVER;
        end
      end
      ST_WR_SETUP: begin
        // Select and lanes already low, write begins now
        we_n_nxt    = 1'b0;
        timer_load  = 1'b1;
        timer_value = TIMER_WIDTH'(TURNOFF_CYC); // device floats its outputs
        state_nxt   = ST_WR_TURNOFF;
      end
      ST_WR_TURNOFF: begin
        if (timer_last) begin
          doe_nxt     = 1'b1; // bus free, drive write data
          timer_load  = 1'b1;
          timer_value = TIMER_WIDTH'(WR_DATA_CYC); // data setup and pulse width
          state_nxt   = ST_WR_DATA;
        end
      end
      ST_WR_DATA: begin
        if (timer_last) begin
          we_n_nxt  = 1'b1; // write strobe alone ends the write
          state_nxt = ST_WR_END;
        end
      end
      ST_WR_END: begin
        // Data, address and select held one cycle past the end
        cs_n_nxt    = 1'b1;
        lanes_n_nxt = LANES_OFF;
        doe_nxt     = 1'b0;
        done_nxt    = 1'b1;
        timer_load  = 1'b1;
        timer_value = TIMER_WIDTH'(RELEASE_CYC); // gap between cycles
        state_nxt   = ST_RECOVER;
      end
      ST_RECOVER: begin
        if (timer_last) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        cs_n_nxt    = 1'b1;
        oe_n_nxt    = 1'b1;
        we_n_nxt    = 1'b1;
        lanes_n_nxt = LANES_OFF;
        doe_nxt     = 1'b0;
        state_nxt   = ST_IDLE;
      end
    endcase
    ready_nxt = (state_nxt == ST_IDLE);
  end

  // Sequencer registers
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r   <= ST_IDLE;
      addr_r    <= '0;
      cs_n_r    <= 1'b1;
      oe_n_r    <= 1'b1;
      we_n_r    <= 1'b1;
      lanes_n_r <= LANES_OFF;
      wdata_r   <= '0;
      doe_r     <= 1'b0;
      rdata_r   <= '0;
      ready_r   <= 1'b0;
      done_r    <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      addr_r    <= addr_nxt;
      cs_n_r    <= cs_n_nxt;
      oe_n_r    <= oe_n_nxt;
      we_n_r    <= we_n_nxt;
      lanes_n_r <= lanes_n_nxt;
      wdata_r   <= wdata_nxt;
      doe_r     <= doe_nxt;
      rdata_r   <= rdata_nxt;
      ready_r   <= ready_nxt;
      done_r    <= done_nxt;
    end
  end

  // Outputs straight from registers
  assign sram_addr_o             = addr_r;
  assign device_select_n_o       = cs_n_r;
  assign output_drive_enable_n_o = oe_n_r;
  assign write_strobe_n_o        = we_n_r;
  assign upper_lane_strobe_n_o   = lanes_n_r[1];
  assign lower_lane_strobe_n_o   = lanes_n_r[0];
  assign sram_data_o             = wdata_r;
  assign sram_data_oe_o          = doe_r;
  assign rdata_o                 = rdata_r;
  assign ready_o                 = ready_r;
  assign done_o                  = done_r;

  // Checking helpers: write-low cycle count and fixed delays
  localparam int RD_DONE_DLY = READ_WAIT_CYC;
  logic [TIMER_WIDTH-1:0] we_low_cnt_r;
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      we_low_cnt_r <= '0;
    end else if (!we_n_r) begin
      we_low_cnt_r <= we_low_cnt_r + TIMER_WIDTH'(1);
    end else begin
      we_low_cnt_r <= '0;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_write_end;
    $rose(write_strobe_n_o);
  endsequence

  sequence s_read_start;
    $fell(output_drive_enable_n_o);
  endsequence

  a_write_qualify: assert property (!write_strobe_n_o |-> !device_select_n_o &&
    !(upper_lane_strobe_n_o && lower_lane_strobe_n_o)) else $error("write strobe without select or lane");
  a_strobes_steady: assert property (!write_strobe_n_o && $past(!write_strobe_n_o) |->
    $stable({device_select_n_o, upper_lane_strobe_n_o, lower_lane_strobe_n_o}))
    else $error("qualifying strobes moved during write");
  a_data_setup: assert property (s_write_end |-> sram_data_oe_o && $past(sram_data_oe_o)
    && $stable(sram_data_o)) else $error("write data not set up before write end");
  a_pulse_width: assert property (s_write_end |-> we_low_cnt_r == TIMER_WIDTH'(WR_LOW_CYC))
    else $error("write strobe low time wrong");
  a_oe_off_write: assert property (!write_strobe_n_o |-> output_drive_enable_n_o)
    else $error("output enable low during write");
  a_addr_stable: assert property (!device_select_n_o && $past(!device_select_n_o) |->
    $stable(sram_addr_o)) else $error("address moved while selected");
  a_select_lead: assert property (s_write_end |-> !device_select_n_o && $past(!device_select_n_o, 2)
    ##1 device_select_n_o ##1 device_select_n_o) else $error("select timing around write end");
  a_read_done: assert property (s_read_start |-> !device_select_n_o ##RD_DONE_DLY done_o
    && device_select_n_o) else $error("read result late or early");
  a_no_contention: assert property (sram_data_oe_o |-> output_drive_enable_n_o &&
    $past(output_drive_enable_n_o, 2) && $past(!write_strobe_n_o)) else $error("data driven into live bus");

endmodule

`default_nettype wire

// [design/sram_host_pkg.sv]
// Constants and timing helpers for the asynchronous SRAM host controller
package sram_host_pkg;

  // Geometry of the attached memory
  localparam int ADDR_WIDTH = 18;
  localparam int DATA_WIDTH = 16;
  localparam int LANE_COUNT = 2;

  // Controller clock period in picoseconds (25 MHz)
  localparam int CLK_PERIOD_PS = 40_000;

  // Read timing of the device, picoseconds
  localparam int ADDRESS_TO_DATA_DELAY_PS = 20_000; // address to valid data, max
  localparam int SELECT_TO_DATA_DELAY_PS  = 20_000; // select to valid data, max
  localparam int LANE_TO_DATA_DELAY_PS    = 8_000;  // lane strobe to valid data, max
  localparam int OUTPUT_FLOAT_DELAY_PS    = 8_000;  // select/enable/lane rise to float, max
  localparam int DATA_HOLD_AFTER_ADDRESS_PS = 2_500; // old data kept after address change, min

  // Write timing of the device, picoseconds
  localparam int WRITE_CYCLE_MIN_PS        = 20_000;
  localparam int ADDRESS_VALID_TO_WRITE_END_PS = 12_000;
  localparam int WRITE_PULSE_MIN_PS        = 12_000;
  localparam int WRITE_PULSE_MIN_OUTPUTS_ON_PS = 17_000;
  localparam int WRITE_DATA_SETUP_PS       = 9_000;
  localparam int WRITE_DATA_HOLD_PS        = 0;
  localparam int WRITE_TURNOFF_DELAY_PS    = 9_000;
  localparam int WRITE_END_TURNON_DELAY_PS = 3_000;

  // Least time rounded up to whole cycles, never below one
  function automatic int cycles_min(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // Longest time rounded down to whole cycles, never below one
  function automatic int cycles_max(input int ps);
    int c;
    c = ps / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // Larger of two counts
  function automatic int max_int(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  // Input synchroniser depth on the data pins
  localparam int SYNC_STAGES = 2;

  // Derived cycle counts
  localparam int READ_ACCESS_CYC = max_int(cycles_min(ADDRESS_TO_DATA_DELAY_PS),
                                           max_int(cycles_min(SELECT_TO_DATA_DELAY_PS),
                                                   cycles_min(LANE_TO_DATA_DELAY_PS)));
  localparam int READ_WAIT_CYC   = READ_ACCESS_CYC + SYNC_STAGES;
  localparam int RELEASE_CYC     = max_int(cycles_max(OUTPUT_FLOAT_DELAY_PS),
                                           cycles_min(WRITE_END_TURNON_DELAY_PS));
  localparam int TURNOFF_CYC     = cycles_max(WRITE_TURNOFF_DELAY_PS);
  localparam int SETUP_CYC       = cycles_min(WRITE_DATA_SETUP_PS);
  localparam int PULSE_CYC       = max_int(cycles_min(WRITE_PULSE_MIN_PS),
                                           cycles_min(ADDRESS_VALID_TO_WRITE_END_PS));
  localparam int WR_DATA_CYC     = max_int(SETUP_CYC, PULSE_CYC - TURNOFF_CYC);
  localparam int WR_LOW_CYC      = TURNOFF_CYC + WR_DATA_CYC;

  // Wait timer width, idle lane pin value and all-lanes request mask
  localparam int            TIMER_WIDTH = 4;
  localparam logic [1:0]    LANES_OFF   = 2'h3;
  localparam logic [1:0]    LANES_ALL   = 2'h3;

endpackage

// [design/sram_wait_timer.sv]
// Down-counting wait timer for the SRAM host controller
`timescale 1ns/10ps
`default_nettype none

module sram_wait_timer
  import sram_host_pkg::*;
#(
  parameter int WIDTH = TIMER_WIDTH
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             reset_n_i,
  // Control
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] load_value_i,
  // Status
  output logic                  last_o
);

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;

  // Reload or count down, stopping at one
  always_comb begin
    count_nxt = count_r;
    if (load_i) begin
      count_nxt = load_value_i;
    end else if (count_r > WIDTH'(1)) begin
      count_nxt = count_r - WIDTH'(1);
    end
  end

  // Counter register
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  // Final cycle of the loaded span
  assign last_o = (count_r <= WIDTH'(1));

endmodule

`default_nettype wire

// [verification/sram_dev_model.sv]
// Behavioural model of the byte-lane asynchronous SRAM on the controller pins
`timescale 1ns/10ps
`default_nettype none
module sram_dev_model
  import sram_host_pkg::*;
(
  // Device pins
  input  wire logic [ADDR_WIDTH-1:0] addr_i,
  input  wire logic                  sel_n_i,
  input  wire logic                  oe_n_i,
  input  wire logic                  we_n_i,
  input  wire logic [1:0]            lane_n_i,
  input  wire logic [DATA_WIDTH-1:0] bus_i,
  input  wire logic                  host_oe_i,
  // Device drive and breaches seen
  output logic [DATA_WIDTH-1:0]      dq_o,
  output logic [1:0]                 dq_oe_o,
  output int                         viol_o
);
  logic [DATA_WIDTH-1:0] mem [logic [ADDR_WIDTH-1:0]];
  logic [DATA_WIDTH-1:0] w;
  logic [1:0]            on, wl;
  logic                  wr;
  logic                  in_wr = 1'b0;
  realtime               t_a, t_d, t_s, t_w, dt;
  realtime               t_ws = -100.0;
  realtime               t_c [2] = '{-100.0, -100.0};
  real                   ns = 1000.0;
  // Write window and per-lane read drive
  assign wr = !sel_n_i && !we_n_i && (lane_n_i != 2'h3);
  assign on = {2{!sel_n_i && !oe_n_i && we_n_i}} & ~lane_n_i;
  initial viol_o = 0;
  initial dq_oe_o = 2'h0;
  initial dq_o = 16'h0;
  // Times of the last pin changes
  always @(addr_i) t_a = $realtime;
  always @(bus_i) t_d = $realtime;
  always @(negedge sel_n_i) t_s = $realtime;
  always @(negedge we_n_i) t_w = $realtime;
  always @(on[0]) t_c[0] = $realtime;
  always @(on[1]) t_c[1] = $realtime;
  // Write start: cycle spacing, lanes latched
  always @(posedge wr) begin
    if ($realtime - t_ws < WRITE_CYCLE_MIN_PS / ns) viol_o++;
    t_ws = $realtime;
    wl = ~lane_n_i;
    in_wr = 1'b1;
  end
  // Write end: setup and width checks, selected lanes stored
  always @(negedge wr) begin
    if (in_wr) begin
      in_wr = 1'b0;
      if ($realtime - t_d < WRITE_DATA_SETUP_PS / ns) viol_o++;
      if ($realtime - t_w < (oe_n_i ? WRITE_PULSE_MIN_PS : WRITE_PULSE_MIN_OUTPUTS_ON_PS) / ns) viol_o++;
      if ($realtime - t_a < ADDRESS_VALID_TO_WRITE_END_PS / ns) viol_o++;
      if ($realtime - t_s < 12.0) viol_o++;
      w = mem.exists(addr_i) ? mem[addr_i] : '0;
      if (wl[0]) w[7:0] = bus_i[7:0];
      if (wl[1]) w[15:8] = bus_i[15:8];
      mem[addr_i] = w;
    end
  end
  // Host drive over live lanes, address moving inside a governed read
  always @(posedge host_oe_i) if (dq_oe_o != 2'h0) viol_o++;
  always @(addr_i) begin
    #0.1;
    if (!sel_n_i && !oe_n_i && t_s < $realtime - 0.15) viol_o++;
  end
  // Lane drive each ns: valid after access delays, stale data briefly kept, late float
  always #1 begin
    for (int i = 0; i < 2; i++) begin
      dt = $realtime - t_c[i];
      dq_oe_o[i] = on[i] ? (dt >= 3.0)
                 : (dt < (we_n_i ? OUTPUT_FLOAT_DELAY_PS : WRITE_TURNOFF_DELAY_PS) / ns);
      if (on[i] && $realtime - t_a >= ADDRESS_TO_DATA_DELAY_PS / ns && dt >= LANE_TO_DATA_DELAY_PS / ns
          && $realtime - t_s >= SELECT_TO_DATA_DELAY_PS / ns)
        dq_o[8*i+:8] = mem.exists(addr_i) ? mem[addr_i][8*i+:8] : 8'h00;
      else if ($realtime - t_a >= DATA_HOLD_AFTER_ADDRESS_PS / ns)
        dq_o[8*i+:8] = ~dq_o[8*i+:8];
    end
  end
endmodule
`default_nettype wire

// [verification/tb.sv]
// Testbench for the SRAM host controller against the device model
`timescale 1ns/10ps
`default_nettype none
module tb;
  import sram_host_pkg::*;
  logic                  ref_clk_i, reset_n_i, req_i, req_write_i, ready_o, done_o, wsel;
  logic                  sel_n, oe_n, we_n, ub_n, lb_n, data_oe;
  logic [1:0]            req_lane_en_i, dev_oe;
  logic [ADDR_WIDTH-1:0] req_addr_i, sram_addr, pool [8];
  logic [DATA_WIDTH-1:0] req_wdata_i, rdata_o, sram_wdata, bus, dev_q, float_r;
  logic [DATA_WIDTH-1:0] ref_mem [logic [ADDR_WIDTH-1:0]];
  int                    num_errors = 0, check_count = 0, seed = 13403, viol;

  sram_host_ctrl DUT (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .req_i(req_i), .req_write_i(req_write_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_lane_en_i(req_lane_en_i),
    .ready_o(ready_o), .done_o(done_o), .rdata_o(rdata_o), .sram_addr_o(sram_addr),
    .device_select_n_o(sel_n), .output_drive_enable_n_o(oe_n), .write_strobe_n_o(we_n),
    .upper_lane_strobe_n_o(ub_n), .lower_lane_strobe_n_o(lb_n), .sram_data_o(sram_wdata),
    .sram_data_oe_o(data_oe), .sram_data_i(bus)
  );
  sram_dev_model dev (
    .addr_i(sram_addr), .sel_n_i(sel_n), .oe_n_i(oe_n), .we_n_i(we_n), .lane_n_i({ub_n, lb_n}),
    .bus_i(bus), .host_oe_i(data_oe), .dq_o(dev_q), .dq_oe_o(dev_oe), .viol_o(viol)
  );
  // Clock
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  // Data wire: host, then device lanes, else a pattern toggling each cycle
  always @(posedge ref_clk_i) float_r <= ~float_r;
  assign bus = {data_oe ? sram_wdata[15:8] : dev_oe[1] ? dev_q[15:8] : float_r[15:8],
                data_oe ? sram_wdata[7:0] : dev_oe[0] ? dev_q[7:0] : float_r[7:0]};
  // Verdict and closing
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Comparisons, one per kind of result
  task automatic check_data(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: read %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic check_pin(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s is %b", $time, what, got);
    end
  endtask
  task automatic check_num(input int got, input int exp, input string what);
    check_count++;
    if (got != exp) begin
      num_errors++;
      $display("Error at %0t: %s %0d, expected %0d", $time, what, got, exp);
    end
  endtask
  task automatic timed_out();
    num_errors++;
    $display("Error at %0t: wait limit reached", $time);
    print_verdict();
  endtask
  // Expected word after a masked write
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] ln);
    logic [1:0] m;
    m = (ln == 2'h0) ? 2'h3 : ln;
    return {m[1] ? nw[15:8] : old[15:8], m[0] ? nw[7:0] : old[7:0]};
  endfunction
  // Pins quiet and handshake low
  task automatic check_idle();
    check_pin(sel_n, 1'b1, "select");
    check_pin(we_n, 1'b1, "write strobe");
    check_pin(oe_n, 1'b1, "output enable");
    check_pin(data_oe, 1'b0, "data drive");
    check_pin(ready_o, 1'b0, "ready");
    check_pin(done_o, 1'b0, "done");
  endtask
  // One request: wait ready, present for one edge, time completion, compare
  task automatic access(input logic wr, input logic [17:0] a, input logic [15:0] d, input logic [1:0] ln);
    int n;
    n = 0;
    while (ready_o !== 1'b1) begin
      @(negedge ref_clk_i);
      if (++n > 20) timed_out();
    end
    req_i = 1'b1;
    req_write_i = wr;
    req_addr_i = a;
    req_wdata_i = d;
    req_lane_en_i = ln;
    @(negedge ref_clk_i);
    req_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1) begin
      @(negedge ref_clk_i);
      if (++n > 20) timed_out();
    end
    if (wr) check_num(n, WR_LOW_CYC + 2, "write latency");
    else check_num(n, READ_WAIT_CYC, "read latency");
    if (wr) ref_mem[a] = merge(ref_mem.exists(a) ? ref_mem[a] : 16'h0, d, ln);
    else check_data(rdata_o, ref_mem[a]);
    @(negedge ref_clk_i);
    check_pin(done_o, 1'b0, "done after one cycle");
  endtask
  // Main sequence
  initial begin
    reset_n_i = 1'b0;
    req_i = 1'b0;
    req_write_i = 1'b0;
    req_addr_i = '0;
    req_wdata_i = '0;
    req_lane_en_i = 2'h0;
    float_r = 16'h5aa5;
    repeat (8) @(negedge ref_clk_i);
    check_idle();
    reset_n_i = 1'b1;
    @(negedge ref_clk_i);
    check_pin(ready_o, 1'b1, "ready after reset");
    $display("Test reset done");
    access(1'b1, 18'h0, 16'h1234, 2'h3);
    access(1'b1, 18'h3ffff, 16'hffff, 2'h0);
    for (int m = 0; m < 4; m++) begin
      access(1'b1, 18'h3ffff, 16'(16'h1111 * (m + 1)), m[1:0]);
      access(1'b0, 18'h3ffff, 16'h0, 2'h3);
    end
    access(1'b0, 18'h0, 16'h0, 2'h0);
    $display("Test lanes done");
    for (int i = 0; i < 8; i++) begin
      pool[i] = 18'($random(seed));
      access(1'b1, pool[i], 16'($random(seed)), 2'h3);
    end
    for (int i = 0; i < 60; i++) begin
      wsel = 1'($random(seed));
      access(wsel, pool[3'($random(seed))], 16'($random(seed)), wsel ? 2'($random(seed)) : 2'h3);
    end
    $display("Test random done");
    @(negedge ref_clk_i);
    check_pin(ready_o, 1'b1, "ready two cycles after done");
    req_addr_i = pool[0];
    req_write_i = 1'b0;
    req_i = 1'b1;
    @(negedge ref_clk_i);
    req_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    check_pin(sel_n, 1'b0, "select during read");
    reset_n_i = 1'b0;
    #1;
    check_idle();
    @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    access(1'b0, pool[0], 16'h0, 2'h3);
    check_num(viol, 0, "device timing breaches");
    $display("Test abort done");
    print_verdict();
  end
endmodule
`default_nettype wire
